//--- mbst_jtag_ctl.sv
module mbst_jtag_ctl (
   output mbst_pkg::mbst_jtag_t jtag,
   input  wire logic            tdo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial jtag = '0;
   // tck only runs inside operations, 320 ns period
   task automatic bit1(input logic m, input logic d, output logic q);
      jtag.tms <= m;
      jtag.tdi <= d;
      #160;
      q = tdo;
      jtag.tck <= 1'b1;
      #160;
      jtag.tck <= 1'b0;
   endtask : bit1
   // callers only pass documented codes
   task automatic ir(input logic [2:0] c, output logic [2:0] cap);
      logic q;
      bit1(1, 0, q);
      bit1(1, 0, q);
      bit1(0, 0, q);
      bit1(0, 0, q);
      for (int i = 0; i < 3; i++) begin
         bit1(i == 2, c[i], q);
         cap[i] = q;
      end
      bit1(1, 0, q);
      bit1(0, 0, q);
      // let the synchronised update reach the pins before anyone looks
      #320;
   endtask : ir
   task automatic dr(input int n, input logic [108:0] d, output logic [108:0] o);
      logic q;
      o = '0;
      bit1(1, 0, q);
      bit1(0, 0, q);
      bit1(0, 0, q);
      for (int i = 0; i < n; i++) begin
         bit1(i == n - 1, d[i], q);
         o[i] = q;
      end
      bit1(1, 0, q);
      bit1(0, 0, q);
      #320;
   endtask : dr
   task automatic tlr();
      logic q;
      repeat (6) bit1(1, 0, q);
      bit1(0, 0, q);
   endtask : tlr
endmodule : mbst_jtag_ctl

//--- mbst_pkg.sv
package mbst_pkg;
   localparam int IR_W      = 3;
   localparam int ID_W      = 32;
   localparam int BSR_W     = 109;
   localparam int PIN_W     = 108;
   localparam int OE_CELL   = 108;
   localparam int TCK_MIN_NS = 50;
   localparam int TDO_MAX_NS = 10;

   localparam logic [IR_W-1:0] IR_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0] IR_IDCODE  = 3'h1;
   localparam logic [IR_W-1:0] IR_SAMPLEZ = 3'h2;
   localparam logic [IR_W-1:0] IR_SAMPLE  = 3'h4;
   localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

   localparam logic [1:0] SEL_BYP = 2'h0;
   localparam logic [1:0] SEL_ID  = 2'h1;
   localparam logic [1:0] SEL_BSR = 2'h2;

   typedef enum logic [3:0] {
      ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
      ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
   } mbst_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } mbst_jtag_t;
endpackage : mbst_pkg

//--- mbst_tap.sv
module mbst_tap #(
   parameter logic [10:0] MAKER_CODE = 11'h000,   // arbitrary value
   parameter logic [16:0] PART_CODE  = 17'h0_0000, // arbitrary value
   parameter logic [2:0]  VER_CODE   = 3'h2        // arbitrary value
) (
   input  wire logic                       core_clk,
   input  wire logic                       nrst,
   input  wire logic                       tck,
   input  wire logic                       tms,
   input  wire logic                       tdi,
   output logic                            tdo,
   output logic                            tdo_oe_n,
   input  wire logic [mbst_pkg::PIN_W-1:0] pin_in,
   input  wire logic [mbst_pkg::PIN_W-1:0] core_out,
   output logic      [mbst_pkg::PIN_W-1:0] pin_out,
   output logic                            pin_oe_n
);
   // tck period 320 ns gives 8 core clocks per tck, enough to sample edges
   logic [2:0]                  tck_s1_r;
   logic [2:0]                  tck_s2_r;
   logic                        tck_d_r;
   mbst_pkg::mbst_jtag_t        jt;
   mbst_pkg::mbst_state_t       st_r, st_nxt;
   logic [mbst_pkg::IR_W-1:0]   ir_sh_r;
   logic [mbst_pkg::IR_W-1:0]   ir_r;
   logic                        byp_r;
   logic [mbst_pkg::ID_W-1:0]   id_sh_r;
   logic [mbst_pkg::BSR_W-1:0]  bsr_sh_r;
   logic [mbst_pkg::BSR_W-1:0]  bsr_up_r;
   logic [mbst_pkg::PIN_W-1:0]  pin_cap_s1_r;
   logic [mbst_pkg::PIN_W-1:0]  pin_cap_s2_r;
   logic                        tdo_nxt_r;
   logic                        shifting_r;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tck_s1_r <= 3'h0;
         tck_s2_r <= 3'h0;
         tck_d_r  <= 1'b0;
      end else begin
         tck_s1_r <= {tck, tms, tdi};
         tck_s2_r <= tck_s1_r;
         tck_d_r  <= tck_s2_r[2];
      end
   end

   // pins sampled on core clock; values caught mid-transition may still be wrong
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_cap_s1_r <= '0;
         pin_cap_s2_r <= '0;
      end else begin
         pin_cap_s1_r <= pin_in;
         pin_cap_s2_r <= pin_cap_s1_r;
      end
   end

   assign jt = mbst_pkg::mbst_jtag_t'(tck_s2_r);
   wire tck_rise = jt.tck & ~tck_d_r;
   wire tck_fall = ~jt.tck & tck_d_r;

   // test-port state walk; every code is a legal state, so no default is needed
   function automatic mbst_pkg::mbst_state_t tap_next(input mbst_pkg::mbst_state_t s, input logic m);
      tap_next = s;
      unique case (s)
         mbst_pkg::ST_RESET: begin
            if (m) begin
               tap_next = mbst_pkg::ST_RESET;
            end else begin
               tap_next = mbst_pkg::ST_IDLE;
            end
         end
         mbst_pkg::ST_IDLE: begin
            if (m) begin
               tap_next = mbst_pkg::ST_SEL_DR;
            end else begin
               tap_next = mbst_pkg::ST_IDLE;
            end
         end
         mbst_pkg::ST_SEL_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_SEL_IR;
            end else begin
               tap_next = mbst_pkg::ST_CAP_DR;
            end
         end
         mbst_pkg::ST_CAP_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_EX1_DR;
            end else begin
               tap_next = mbst_pkg::ST_SH_DR;
            end
         end
         mbst_pkg::ST_SH_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_EX1_DR;
            end else begin
               tap_next = mbst_pkg::ST_SH_DR;
            end
         end
         mbst_pkg::ST_EX1_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_UPD_DR;
            end else begin
               tap_next = mbst_pkg::ST_PAU_DR;
            end
         end
         mbst_pkg::ST_PAU_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_EX2_DR;
            end else begin
               tap_next = mbst_pkg::ST_PAU_DR;
            end
         end
         mbst_pkg::ST_EX2_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_UPD_DR;
            end else begin
               tap_next = mbst_pkg::ST_SH_DR;
            end
         end
         mbst_pkg::ST_UPD_DR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_SEL_DR;
            end else begin
               tap_next = mbst_pkg::ST_IDLE;
            end
         end
         mbst_pkg::ST_SEL_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_RESET;
            end else begin
               tap_next = mbst_pkg::ST_CAP_IR;
            end
         end
         mbst_pkg::ST_CAP_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_EX1_IR;
            end else begin
               tap_next = mbst_pkg::ST_SH_IR;
            end
         end
         mbst_pkg::ST_SH_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_EX1_IR;
            end else begin
               tap_next = mbst_pkg::ST_SH_IR;
            end
         end
         mbst_pkg::ST_EX1_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_UPD_IR;
            end else begin
               tap_next = mbst_pkg::ST_PAU_IR;
            end
         end
         mbst_pkg::ST_PAU_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_EX2_IR;
            end else begin
               tap_next = mbst_pkg::ST_PAU_IR;
            end
         end
         mbst_pkg::ST_EX2_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_UPD_IR;
            end else begin
               tap_next = mbst_pkg::ST_SH_IR;
            end
         end
         mbst_pkg::ST_UPD_IR: begin
            if (m) begin
               tap_next = mbst_pkg::ST_SEL_DR;
            end else begin
               tap_next = mbst_pkg::ST_IDLE;
            end
         end
      endcase
   endfunction : tap_next

   always_comb begin
      st_nxt = tap_next(st_r, jt.tms);
   end

   // instruction decode; reserved codes fall to bypass for safety
   wire is_extest  = (ir_r == mbst_pkg::IR_EXTEST);
   wire is_idcode  = (ir_r == mbst_pkg::IR_IDCODE);
   wire is_samplez = (ir_r == mbst_pkg::IR_SAMPLEZ);
   wire is_sample  = (ir_r == mbst_pkg::IR_SAMPLE);
   wire sel_bsr    = is_extest | is_samplez | is_sample;
   wire [1:0] dr_sel = sel_bsr ? mbst_pkg::SEL_BSR :
                       is_idcode ? mbst_pkg::SEL_ID : mbst_pkg::SEL_BYP;

   wire [mbst_pkg::ID_W-1:0] id_val = {VER_CODE, PART_CODE, MAKER_CODE, 1'b1};
   wire [mbst_pkg::BSR_W-1:0] ring = {bsr_up_r[mbst_pkg::OE_CELL], pin_cap_s2_r};

   wire in_cap_dr = tck_rise && (st_r == mbst_pkg::ST_CAP_DR);
   wire in_sh_dr  = tck_rise && (st_r == mbst_pkg::ST_SH_DR);
   wire in_upd_dr = tck_rise && (st_r == mbst_pkg::ST_UPD_DR);
   wire in_cap_ir = tck_rise && (st_r == mbst_pkg::ST_CAP_IR);
   wire in_sh_ir  = tck_rise && (st_r == mbst_pkg::ST_SH_IR);
   wire in_upd_ir = tck_rise && (st_r == mbst_pkg::ST_UPD_IR);
   wire in_reset  = (st_r == mbst_pkg::ST_RESET);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= mbst_pkg::ST_RESET;
      end else if (tck_rise) begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ir_sh_r <= mbst_pkg::IR_CAPTURE;
         ir_r    <= mbst_pkg::IR_IDCODE;
      end else if (in_reset) begin
         ir_r    <= mbst_pkg::IR_IDCODE;
      end else if (in_cap_ir) begin
         ir_sh_r <= mbst_pkg::IR_CAPTURE;
      end else if (in_sh_ir) begin
         ir_sh_r <= {jt.tdi, ir_sh_r[mbst_pkg::IR_W-1:1]};
      end else if (in_upd_ir) begin
         ir_r    <= ir_sh_r;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         byp_r   <= 1'b0;
         id_sh_r <= '0;
      end else if (in_cap_dr) begin
         byp_r   <= 1'b0;
         id_sh_r <= id_val;
      end else if (in_sh_dr) begin
         byp_r   <= jt.tdi;
         id_sh_r <= {jt.tdi, id_sh_r[mbst_pkg::ID_W-1:1]};
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bsr_sh_r <= '0;
      end else if (in_cap_dr && sel_bsr) begin
         bsr_sh_r <= ring;
      end else if (in_sh_dr && sel_bsr) begin
         bsr_sh_r <= {jt.tdi, bsr_sh_r[mbst_pkg::BSR_W-1:1]};
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bsr_up_r <= '0;
      end else if (in_reset) begin
         bsr_up_r[mbst_pkg::OE_CELL] <= 1'b0;
      end else if (in_upd_dr && sel_bsr) begin
         bsr_up_r <= bsr_sh_r;                                     // preload latch
      end
   end

   // serial output picked on every core clock, launched on the falling tck edge
   wire tdo_src = (dr_sel == mbst_pkg::SEL_BSR) ? bsr_sh_r[0] :
                  (dr_sel == mbst_pkg::SEL_ID)  ? id_sh_r[0]  : byp_r;
   wire ir_path = (st_r == mbst_pkg::ST_SH_IR);
   wire dr_path = (st_r == mbst_pkg::ST_SH_DR);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tdo_nxt_r  <= 1'b0;
         shifting_r <= 1'b0;
         tdo        <= 1'b0;
         tdo_oe_n   <= 1'b1;
      end else begin
         tdo_nxt_r  <= ir_path ? ir_sh_r[0] : tdo_src;
         shifting_r <= ir_path | dr_path;
         if (tck_fall) begin
            tdo      <= tdo_nxt_r;
            tdo_oe_n <= ~shifting_r;
         end
      end
   end

   // output drivers: extest drives preload when the OE cell holds 1, samplez floats, else core runs
   wire [mbst_pkg::PIN_W-1:0] pin_out_nxt = is_extest ? bsr_up_r[mbst_pkg::PIN_W-1:0] : core_out;
   wire pin_oe_n_nxt = is_samplez ? 1'b1 :
                       is_extest  ? ~bsr_up_r[mbst_pkg::OE_CELL] : 1'b0;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_out  <= '0;
         pin_oe_n <= 1'b0;
      end else begin
         pin_out  <= pin_out_nxt;
         pin_oe_n <= pin_oe_n_nxt;
      end
   end
endmodule : mbst_tap

//--- mbst_tap_assertions.sv
module mbst_tap_chk (
   input wire logic         core_clk,
   input wire logic         nrst,
   input wire logic         tck,
   input wire logic         tms,
   input wire logic         tdi,
   input wire logic         tdo,
   input wire logic         tdo_oe_n,
   input wire logic [107:0] pin_in,
   input wire logic [107:0] core_out,
   input wire logic [107:0] pin_out,
   input wire logic         pin_oe_n
);
   logic [1:0] tck_s_r;
   logic [3:0] hi_cnt_r;
   logic       tms_last_r;
   wire        tck_rise   = tck_s_r[0] & ~tck_s_r[1];
   wire  [3:0] hi_cnt_nxt = !tms ? 4'h0 : (hi_cnt_r == 4'hf) ? 4'hf : hi_cnt_r + 4'h1;
   // one extra rise of margin: our detector runs a clock ahead of the design's
   wire        in_tlr     = hi_cnt_r >= 4'h6;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tck_s_r <= 2'h0;
         hi_cnt_r <= 4'h0;
         tms_last_r <= 1'b1;
      end else begin
         tck_s_r <= {tck_s_r[0], tck};
         if (tck_rise) begin
            hi_cnt_r <= hi_cnt_nxt;
            tms_last_r <= tms;
         end
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence tdo_hold;
      $stable(tdo)[*7];
   endsequence
   chk_tdo_on_low:   assert property ($changed(tdo) |-> !tck) else $error("tdo moved while tck high");
   chk_tdo_holds:    assert property ($changed(tdo) |=> tdo_hold) else $error("tdo did not stand");
   chk_oe_on_low:    assert property ($changed(tdo_oe_n) |-> !tck) else $error("tdo enable moved on high tck");
   chk_shift_entry:  assert property ($fell(tdo_oe_n) |-> !tms_last_r) else $error("tdo driven outside shift");
   chk_oe_at_update: assert property ($changed(pin_oe_n) |-> $past(tck_rise, 2) || $past(tck_rise, 3) || $past(tck_rise, 4)) else $error("pin enable moved off update");
   chk_tlr_oe:       assert property (in_tlr |-> !pin_oe_n && tdo_oe_n) else $error("enables wrong in reset state");
   chk_tlr_pass:     assert property (in_tlr |-> pin_out == $past(core_out)) else $error("pins not from core");
   chk_reset_vals:   assert property ($rose(nrst) |-> tdo_oe_n && !pin_oe_n && !tdo) else $error("bad reset values");
endmodule : mbst_tap_chk

bind mbst_tap mbst_tap_chk mbst_tap_chk_i (.core_clk(core_clk), .nrst(nrst), .tck(tck), .tms(tms),
   .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
   .pin_out(pin_out), .pin_oe_n(pin_oe_n));

//--- memory_boundary_scan_tap_tb.sv
module memory_boundary_scan_tap_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0]  ID   = {3'h5, 17'h1_2345, 11'h2a5, 1'b1}; // arbitrary codes
   localparam logic [107:0] PAT  = {27{4'h6}};
   localparam logic [107:0] CORE = {27{4'h9}};
   localparam logic [108:0] PRE1 = {1'b1, {27{4'h3}}};
   localparam logic [108:0] PRE2 = {1'b0, {27{4'hc}}};
   logic                 core_clk = 1'b0;
   logic                 nrst = 1'b0;
   logic [107:0]         pin_in = PAT;
   logic [107:0]         core_out = CORE;
   logic                 tdo, tdo_oe_n, pin_oe_n;
   logic [107:0]         pin_out;
   mbst_pkg::mbst_jtag_t jtag;
   logic [2:0]           cap;
   logic [108:0]         o;
   int                   bad_count = 0;
   int                   tests_run = 0;
   always #20 core_clk = ~core_clk;
   mbst_tap #(.MAKER_CODE(ID[11:1]), .PART_CODE(ID[28:12]), .VER_CODE(ID[31:29])) mbst_tap_i (
      .core_clk(core_clk), .nrst(nrst), .tck(jtag.tck), .tms(jtag.tms), .tdi(jtag.tdi),
      .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .core_out(core_out),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n));
   mbst_jtag_ctl mbst_jtag_ctl_i (.jtag(jtag), .tdo(tdo));
   task automatic chk(input logic [159:0] got, input logic [159:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      if (bad_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   initial begin
      #1_000_000;
      bad_count++;
      test_done();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk({tdo_oe_n, pin_oe_n}, 2'b10);
      mbst_jtag_ctl_i.tlr();
      mbst_jtag_ctl_i.dr(32, '0, o);
      chk(o[31:0], ID);
      mbst_jtag_ctl_i.ir(mbst_pkg::IR_BYPASS, cap);
      chk(cap, 3'h1);
      mbst_jtag_ctl_i.dr(2, 109'h3, o);
      chk(o[1:0], 2'h2);
      mbst_jtag_ctl_i.ir(mbst_pkg::IR_SAMPLE, cap);
      mbst_jtag_ctl_i.dr(109, PRE1, o);
      chk({pin_oe_n, pin_out, o}, {1'b0, CORE, 1'b0, PAT});
      mbst_jtag_ctl_i.ir(mbst_pkg::IR_EXTEST, cap);
      chk({pin_oe_n, pin_out}, {1'b0, PRE1[107:0]});
      mbst_jtag_ctl_i.dr(109, PRE2, o);
      chk({pin_oe_n, pin_out, o}, {1'b1, PRE2[107:0], 1'b1, PAT});
      mbst_jtag_ctl_i.ir(mbst_pkg::IR_SAMPLEZ, cap);
      mbst_jtag_ctl_i.dr(109, PRE1, o);
      chk({pin_oe_n, o}, {1'b1, 1'b0, PAT});
      mbst_jtag_ctl_i.ir(mbst_pkg::IR_IDCODE, cap);
      mbst_jtag_ctl_i.dr(32, '0, o);
      chk({pin_oe_n, pin_out, o[31:0]}, {1'b0, CORE, ID});
      mbst_jtag_ctl_i.tlr();
      mbst_jtag_ctl_i.ir(mbst_pkg::IR_EXTEST, cap);
      chk(pin_oe_n, 1'b1);
      test_done();
   end
endmodule : memory_boundary_scan_tap_tb
